// ===== src/fractional_ramp_modulator.sv
// Fractional divide modulator: slip cells, FSK, PSK and ramp generator
//
// Notes on behaviour
// - Predicted slip switches on one extra cell
// - Each further prediction adds a cell, seven max
// - After overshoot, cells switch off one by one
// - Slip logic runs only with its enable bit
// - FSK toggles add or subtract scaled deviation
// - Deviation is 16-bit word shifted by 4-bit
// - PSK pin level picks 0 or 180 degrees
// - Four waveforms: burst, sawtooth burst, sawtooth, triangle
// - Step interval is divider a, times divider b in ramp divide mode
// - 20-bit count sets steps per segment
// - Single burst adds per interval, then holds
// - Sawtooth burst restores start value, then holds
// - Sawtooth ramp repeats sawtooth burst until disabled
// - Triangle steps down equally, then up again
// - Divide value carries a 25-bit fraction
// - Mode code 01 triangle, 11 single burst
// - Select bit picks timer or pin edges
`timescale 1ns/1ps
`default_nettype none
module fractional_ramp_modulator (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [ramp_mod_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [ramp_mod_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [ramp_mod_pkg::DATA_W-1:0] reg_rdata_out,
   // Modulation pin
   input wire logic tx_data_in,
   // Phase detector slip indications
   input wire logic slip_predict_in,
   input wire logic slip_overshoot_in,
   input wire logic tune_up_in,
   // Divider and charge pump controls
   output logic [ramp_mod_pkg::INT_W-1:0] n_int_out,
   output logic [ramp_mod_pkg::FRAC_W-1:0] n_frac_out,
   output logic phase_180_out,
   output logic [ramp_mod_pkg::CELLS-1:0] slip_cells_out,
   output logic slip_source_out
);
   import ramp_mod_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_UP, ST_DOWN, ST_RETURN, ST_HOLD} ramp_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] ctrl;
      logic [FRAC_W-1:0] frac;
      logic [INT_W-1:0] nint;
      logic [DEV_W+SHIFT_W-1:0] dev;
      logic [STEP_W-1:0] steps;
      logic [DIV_W-1:0] div_a;
      logic [DIV_W-1:0] div_b;
      logic [DATA_W-1:0] rdata;
      logic tx_s1;
      logic tx_s2;
      logic tx_s3;
      logic pr_s1;
      logic pr_s2;
      logic pr_s3;
      logic ov_s1;
      logic ov_s2;
      logic ov_s3;
      logic up_s1;
      logic up_s2;
      logic [CELLS-1:0] cells;
      logic unwind;
      logic src;
      logic phase;
      logic start_prev;
      logic tmr_restart;
      ramp_state_t st;
      logic [STEP_W-1:0] cnt;
      logic [N_W-1:0] acc;
   } mod_state_t;

   mod_state_t s_q;
   mod_state_t s_d;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // word times two to the shift
   function automatic logic [N_W-1:0] scaled_dev(input logic [DEV_W+SHIFT_W-1:0] d);
      logic [N_W-1:0] w;
      w = N_W'(signed'(d[DEV_W-1:0]));
      return w << d[DEV_W+SHIFT_W-1:DEV_SHIFT_LO];
   endfunction : scaled_dev

   logic tx_rise;
   logic tx_fall;
   logic pr_rise;
   logic ov_rise;
   logic slip_en;
   logic may_add;
   logic ramp_on;
   logic start_rise;
   logic fsk_en;
   logic psk_en;
   logic step;
   logic last_step;
   logic [1:0] mode;
   logic [N_W-1:0] delta;
   logic [N_W-1:0] center;

   step_timer_if tmr ();

   step_timer u_timer (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .tmr(tmr.timer)
   );

   assign tmr.restart = s_q.tmr_restart;
   // second divider only in ramp divide mode
   assign tmr.use_b = s_q.ctrl[CTRL_DIVB_BIT];
   assign tmr.div_a = s_q.div_a;
   assign tmr.div_b = s_q.div_b;

   // Edge detectors read only the settled stages
   assign tx_rise = s_q.tx_s2 & ~s_q.tx_s3;
   assign tx_fall = ~s_q.tx_s2 & s_q.tx_s3;
   assign pr_rise = s_q.pr_s2 & ~s_q.pr_s3;
   assign ov_rise = s_q.ov_s2 & ~s_q.ov_s3;
   assign slip_en = s_q.ctrl[CTRL_SLIP_BIT];
   assign may_add = slip_en & ~s_q.unwind & ~(ov_rise & (|s_q.cells)) & pr_rise;
   assign ramp_on = s_q.ctrl[CTRL_START_BIT];
   assign start_rise = ramp_on & ~s_q.start_prev;
   assign fsk_en = s_q.ctrl[CTRL_FSK_BIT];
   assign psk_en = s_q.ctrl[CTRL_PSK_BIT];
   assign mode = s_q.ctrl[CTRL_MODE_LO+1:CTRL_MODE_LO];
   // pin or timer, stale tick masked
   assign step = ~s_q.tmr_restart & (s_q.ctrl[CTRL_TXCLK_BIT] ? tx_rise : tmr.tick);
   assign last_step = (s_q.cnt + 20'h0_0001) >= s_q.steps;
   assign delta = scaled_dev(s_q.dev);
   assign center = {s_q.nint, s_q.frac};

   assign reg_rdata_out = s_q.rdata;
   assign n_int_out = s_q.acc[N_W-1:FRAC_W];
   assign n_frac_out = s_q.acc[FRAC_W-1:0];
   assign phase_180_out = s_q.phase;
   assign slip_cells_out = s_q.cells;
   assign slip_source_out = s_q.src;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tx_s1 = tx_data_in;
      s_d.tx_s2 = s_q.tx_s1;
      s_d.tx_s3 = s_q.tx_s2;
      s_d.pr_s1 = slip_predict_in;
      s_d.pr_s2 = s_q.pr_s1;
      s_d.pr_s3 = s_q.pr_s2;
      s_d.ov_s1 = slip_overshoot_in;
      s_d.ov_s2 = s_q.ov_s1;
      s_d.ov_s3 = s_q.ov_s2;
      s_d.up_s1 = tune_up_in;
      s_d.up_s2 = s_q.up_s1;
      s_d.rdata = '0;
      s_d.tmr_restart = 1'b0;
      s_d.start_prev = ramp_on;

      // Register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_CTRL: s_d.ctrl = reg_wdata_in;
            ADDR_FRAC: s_d.frac = reg_wdata_in[FRAC_W-1:0];
            ADDR_INT: s_d.nint = reg_wdata_in[INT_W-1:0];
            ADDR_DEV: s_d.dev = reg_wdata_in[DEV_W+SHIFT_W-1:0];
            ADDR_STEPS: s_d.steps = reg_wdata_in[STEP_W-1:0];
            ADDR_TIMER: begin
               s_d.div_a = reg_wdata_in[DIV_W-1:0];
               s_d.div_b = reg_wdata_in[TIMER_B_LO+DIV_W-1:TIMER_B_LO];
            end
            default: ;
         endcase
      end

      // Register reads, data valid the next cycle only
      if (reg_rd_in) begin
         case (reg_addr_in)
            ADDR_CTRL: s_d.rdata = s_q.ctrl;
            ADDR_FRAC: s_d.rdata = 32'(s_q.frac);
            ADDR_INT: s_d.rdata = 32'(s_q.nint);
            ADDR_DEV: s_d.rdata = 32'(s_q.dev);
            ADDR_STEPS: s_d.rdata = 32'(s_q.steps);
            ADDR_TIMER: s_d.rdata = {4'h0, s_q.div_b, 4'h0, s_q.div_a};
            ADDR_STATUS: s_d.rdata = {s_q.cnt, s_q.unwind, s_q.src,
                                      s_q.cells, 3'(s_q.st)};
            ADDR_NFRAC: s_d.rdata = 32'(s_q.acc[FRAC_W-1:0]);
            ADDR_NINT: s_d.rdata = 32'(s_q.acc[N_W-1:FRAC_W]);
            default: s_d.rdata = '0;
         endcase
      end

      // ------------------------------------------------------------
      // Slip reduction cells
      // ------------------------------------------------------------
      if (!slip_en) begin
         s_d.cells = '0;
         s_d.unwind = 1'b0;
      end else if (s_q.unwind) begin
         s_d.cells = s_q.cells >> 1;
         s_d.unwind = |s_q.cells[CELLS-1:1];
      end else if (ov_rise && (|s_q.cells)) begin
         s_d.unwind = 1'b1;
      end else if (pr_rise) begin
         // add a cell, saturating at seven
         s_d.cells = {s_q.cells[CELLS-2:0], 1'b1};
         s_d.src = s_q.up_s2;
      end

      s_d.phase = psk_en & s_q.tx_s2;

      // ------------------------------------------------------------
      // Ramp and FSK
      // ------------------------------------------------------------
      if (!ramp_on) begin
         s_d.st = ST_IDLE;
         s_d.cnt = '0;
         if (fsk_en) begin
            if (tx_rise) begin
               s_d.acc = s_q.acc + delta;
            end else if (tx_fall) begin
               s_d.acc = s_q.acc - delta;
            end
         end else begin
            s_d.acc = center;
         end
      end else if (start_rise) begin
         s_d.st = ST_UP;
         s_d.cnt = '0;
         s_d.acc = center;
         s_d.tmr_restart = 1'b1;
      end else if (step) begin
         case (s_q.st)
            ST_UP: begin
               s_d.acc = s_q.acc + delta;
               if (last_step) begin
                  s_d.cnt = '0;
                  case (mode)
                     MODE_TRIANGLE: s_d.st = ST_DOWN;
                     MODE_SINGLE_BURST: s_d.st = ST_HOLD;
                     default: s_d.st = ST_RETURN;
                  endcase
               end else begin
                  s_d.cnt = s_q.cnt + 20'h0_0001;
               end
            end
            ST_DOWN: begin
               s_d.acc = s_q.acc - delta;
               if (last_step) begin
                  s_d.cnt = '0;
                  s_d.st = ST_UP;
               end else begin
                  s_d.cnt = s_q.cnt + 20'h0_0001;
               end
            end
            ST_RETURN: begin
               s_d.acc = center;
               s_d.st = (mode == MODE_SAWTOOTH) ? ST_UP : ST_HOLD;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.frac <= FRAC_RST;
         s_q.nint <= INT_RST;
         s_q.dev <= DEV_RST;
         s_q.steps <= STEPS_RST;
         s_q.div_a <= DIV_RST;
         s_q.div_b <= DIV_RST;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_activate;
      start_rise ##1 (s_q.st == ST_UP);
   endsequence

   property p_cell_add;
      may_add && (s_q.cells != 7'h7f) |=> s_q.cells == {$past(s_q.cells[5:0]), 1'b1};
   endproperty
   a_cell_add: assert property (p_cell_add) else $error("slip cell not added");

   property p_cell_max;
      may_add && (s_q.cells == 7'h7f) |=> s_q.cells == 7'h7f;
   endproperty
   a_cell_max: assert property (p_cell_max) else $error("slip cells beyond seven");

   property p_unwind;
      slip_en && s_q.unwind |=> s_q.cells == ($past(s_q.cells) >> 1);
   endproperty
   a_unwind: assert property (p_unwind) else $error("slip cells not released singly");

   property p_slip_off;
      !slip_en |=> s_q.cells == 7'h00;
   endproperty
   a_slip_off: assert property (p_slip_off) else $error("slip cells on while disabled");

   property p_fsk;
      !ramp_on && fsk_en && tx_rise |=> s_q.acc == $past(s_q.acc) + $past(delta);
   endproperty
   a_fsk: assert property (p_fsk) else $error("FSK step wrong");

   property p_psk;
      psk_en ##1 psk_en |-> phase_180_out == $past(s_q.tx_s2);
   endproperty
   a_psk: assert property (p_psk) else $error("PSK phase wrong");

   property p_ramp_up;
      ramp_on && !start_rise && step && (s_q.st == ST_UP)
         |=> s_q.acc == $past(s_q.acc) + $past(delta);
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("ramp up step wrong");

   property p_ramp_down;
      ramp_on && !start_rise && step && (s_q.st == ST_DOWN)
         |=> s_q.acc == $past(s_q.acc) - $past(delta);
   endproperty
   a_ramp_down: assert property (p_ramp_down) else $error("ramp down step wrong");

   property p_return;
      ramp_on && !start_rise && step && (s_q.st == ST_RETURN) |=> s_q.acc == $past(center);
   endproperty
   a_return: assert property (p_return) else $error("sawtooth not restored");

   property p_hold;
      ramp_on ##0 (s_q.st == ST_HOLD) ##1 ramp_on |-> $stable(s_q.acc);
   endproperty
   a_hold: assert property (p_hold) else $error("held value moved");

   property p_start;
      s_activate |-> (s_q.cnt == 20'h0_0000) && (s_q.acc == $past(center)) ##1 tmr.restart == 1'b0;
   endproperty
   a_start: assert property (p_start) else $error("ramp start not from center");
endmodule : fractional_ramp_modulator
`default_nettype wire

// ===== src/ramp_mod_pkg.sv
// Constants and field layout shared by the ramp modulator files
`default_nettype none
package ramp_mod_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int INT_W = 16;
   localparam int FRAC_W = 25;
   localparam int N_W = INT_W + FRAC_W;
   localparam int DEV_W = 16;
   localparam int SHIFT_W = 4;
   localparam int STEP_W = 20;
   localparam int DIV_W = 12;
   localparam int CELLS = 7;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_FRAC = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_INT = 6'h08;
   localparam logic [ADDR_W-1:0] ADDR_DEV = 6'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STEPS = 6'h10;
   localparam logic [ADDR_W-1:0] ADDR_TIMER = 6'h14;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h18;
   localparam logic [ADDR_W-1:0] ADDR_NFRAC = 6'h1c;
   localparam logic [ADDR_W-1:0] ADDR_NINT = 6'h20;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_POL_BIT = 6;
   localparam int CTRL_FSK_BIT = 8;
   localparam int CTRL_PSK_BIT = 9;
   localparam int CTRL_MODE_LO = 10;
   localparam int CTRL_DIVB_BIT = 19;
   localparam int CTRL_SLIP_BIT = 28;
   localparam int CTRL_TXCLK_BIT = 29;
   localparam int CTRL_START_BIT = 31;
   localparam int DEV_SHIFT_LO = 16;
   localparam int TIMER_B_LO = 16;

   // ------------------------------------------------------------
   // Ramp mode codes
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_SAWTOOTH = 2'h0;
   localparam logic [1:0] MODE_TRIANGLE = 2'h1;
   localparam logic [1:0] MODE_SINGLE_SAW = 2'h2;
   localparam logic [1:0] MODE_SINGLE_BURST = 2'h3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [FRAC_W-1:0] FRAC_RST = 25'h000_0000;
   localparam logic [INT_W-1:0] INT_RST = 16'h0000;
   localparam logic [DEV_W+SHIFT_W-1:0] DEV_RST = 20'h0_0000;
   localparam logic [STEP_W-1:0] STEPS_RST = 20'h0_0000;
   localparam logic [DIV_W-1:0] DIV_RST = 12'h001;
endpackage : ramp_mod_pkg
`default_nettype wire

// ===== src/step_timer.sv
// Two-stage divider that paces ramp steps
`timescale 1ns/1ps
`default_nettype none
module step_timer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Sequencer side
   step_timer_if.timer tmr
);
   import ramp_mod_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] a_cnt;
      logic [DIV_W-1:0] b_cnt;
      logic tick;
   } tmr_state_t;

   tmr_state_t s_q;
   tmr_state_t s_d;

   assign tmr.tick = s_q.tick;

   // ------------------------------------------------------------
   // Divider chain
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (tmr.restart) begin
         s_d.a_cnt = '0;
         s_d.b_cnt = '0;
      end else if (s_q.a_cnt + 12'h001 >= tmr.div_a) begin
         s_d.a_cnt = '0;
         // Second stage only counts in ramp divide mode
         if (!tmr.use_b || (s_q.b_cnt + 12'h001 >= tmr.div_b)) begin
            s_d.b_cnt = '0;
            s_d.tick = 1'b1;
         end else begin
            s_d.b_cnt = s_q.b_cnt + 12'h001;
         end
      end else begin
         s_d.a_cnt = s_q.a_cnt + 12'h001;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : step_timer
`default_nettype wire

// ===== src/step_timer_if.sv
// Link between the ramp sequencer and its step timer
`timescale 1ns/1ps
`default_nettype none
interface step_timer_if;
   logic restart;
   logic use_b;
   logic [11:0] div_a;
   logic [11:0] div_b;
   logic tick;
   modport ctrl (output restart, use_b, div_a, div_b, input tick);
   modport timer (input restart, use_b, div_a, div_b, output tick);
endinterface : step_timer_if
`default_nettype wire

// ===== verif/fractional_ramp_modulator_tb.sv
// Self-checking bench for the fractional ramp modulator
`timescale 1ns/1ps
`default_nettype none
module fractional_ramp_modulator_tb;
   import ramp_mod_pkg::*;

   localparam logic [N_W-1:0] CENTER = {16'h0100, 25'h000_0000};
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic tx_data;
   logic slip_predict = 1'b0;
   logic slip_overshoot = 1'b0;
   logic tune_up = 1'b1;
   logic [INT_W-1:0] n_int;
   logic [FRAC_W-1:0] n_frac;
   logic phase_180;
   logic [CELLS-1:0] slip_cells;
   logic slip_source;
   int error_cnt = 0;
   int n_tests = 0;

   always #5 clk_in = ~clk_in;

   host_ctrl_model host (
      .clk_in(clk_in),
      .reg_addr_out(reg_addr),
      .reg_wdata_out(reg_wdata),
      .reg_wr_out(reg_wr),
      .reg_rd_out(reg_rd),
      .reg_rdata_in(reg_rdata),
      .tx_data_out(tx_data)
   );

   fractional_ramp_modulator DUT (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata),
      .tx_data_in(tx_data),
      .slip_predict_in(slip_predict),
      .slip_overshoot_in(slip_overshoot),
      .tune_up_in(tune_up),
      .n_int_out(n_int),
      .n_frac_out(n_frac),
      .phase_180_out(phase_180),
      .slip_cells_out(slip_cells),
      .slip_source_out(slip_source)
   );

   // --------------------------------
   // Checking and closing
   // --------------------------------
   task automatic finish_test();
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_reg

   task automatic chk_out(input logic [N_W-1:0] got, input logic [N_W-1:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_out

   // Read data stands one cycle, then drops to zero
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      host.reg_read(a, d);
      chk_reg(d, e, "register read");
      @(posedge clk_in);
      #1;
      chk_reg(reg_rdata, 32'h0, "read data after its cycle");
   endtask : rd_chk

   task automatic tx_settle(input logic v);
      host.tx_set(v);
      repeat (3) @(posedge clk_in);
      #1;
   endtask : tx_settle

   task automatic pulse_predict();
      @(posedge clk_in);
      slip_predict <= 1'b1;
      repeat (3) @(posedge clk_in);
      slip_predict <= 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
   endtask : pulse_predict

   // Step offsets in delta units: saw 1,2,0 and triangle 1,2,1,0
   function automatic int exp_step(input logic [1:0] m, input int k);
      case (m)
         MODE_TRIANGLE: return (k % 4 == 3) ? 0 : ((k % 4 == 1) ? 2 : 1);
         MODE_SINGLE_BURST: return k + 1;
         default: return (k % 3 == 2) ? 0 : k % 3 + 1;
      endcase
   endfunction : exp_step

   task automatic watch_ramp(input logic [1:0] m, input int gap);
      logic [N_W-1:0] prev;
      int k;
      int last;
      prev = CENTER;
      k = 0;
      last = 0;
      for (int t = 0; t < 60 && k < 6; t++) begin
         @(posedge clk_in);
         #1;
         if ({n_int, n_frac} !== prev) begin
            prev = {n_int, n_frac};
            chk_out(prev, CENTER + N_W'(exp_step(m, k)), "ramp value");
            if (k > 0) begin
               chk_out(N_W'(t - last), N_W'(gap), "step interval");
            end
            last = t;
            k++;
         end
      end
      chk_out(N_W'(k), N_W'(m == 2'h3 ? 2 : (m == 2'h2 ? 3 : 6)), "step count");
   endtask : watch_ramp

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      logic [CELLS-1:0] prev_c;
      logic [DATA_W-1:0] dv [3];
      logic [N_W-1:0] delta;
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      chk_out({n_int, n_frac}, '0, "divide value after reset");
      rd_chk(ADDR_TIMER, 32'h0001_0001);
      rd_chk(ADDR_CTRL, 32'h0);
      rd_chk(6'h3c, 32'h0);
      dv = '{host.dev_word(16'h0003, 4'h4), host.dev_word(16'h0400, 4'hf),
             host.dev_word(16'hfffe, 4'h0)};
      host.reg_write(ADDR_INT, 32'h0000_0100);
      host.reg_write(ADDR_FRAC, 32'h0);
      for (int i = 0; i < 3; i++) begin
         delta = {{25{dv[i][15]}}, dv[i][15:0]} << dv[i][19:16];
         host.reg_write(ADDR_DEV, dv[i]);
         host.reg_write(ADDR_CTRL, 32'h0000_0100);
         tx_settle(1'b1);
         chk_out({n_int, n_frac}, CENTER + delta, "shift up");
         tx_settle(1'b0);
         chk_out({n_int, n_frac}, CENTER, "shift down");
      end
      host.reg_write(ADDR_CTRL, 32'h0000_0200);
      tx_settle(1'b1);
      chk_out(N_W'(phase_180), N_W'(1), "phase 180");
      tx_settle(1'b0);
      chk_out(N_W'(phase_180), N_W'(0), "phase 0");
      host.reg_write(ADDR_CTRL, 32'h0);
      host.reg_write(ADDR_DEV, host.dev_word(16'h0001, 4'h0));
      // unit steps keep the integer rise tiny
      host.reg_write(ADDR_STEPS, 32'h0000_0002);
      host.reg_write(ADDR_TIMER, 32'h0003_0002);
      for (int m = 0; m < 4; m++) begin
         host.reg_write(ADDR_CTRL, 32'h8008_0000 | (32'(m) << CTRL_MODE_LO));
         watch_ramp(2'(m), 6);
         host.reg_write(ADDR_CTRL, 32'h0);
         repeat (3) @(posedge clk_in);
         #1;
         chk_out({n_int, n_frac}, CENTER, "ramp stopped");
      end
      // Without the divider mode bit only the first divider paces steps
      host.reg_write(ADDR_CTRL, 32'h8000_0c00);
      watch_ramp(2'h3, 2);
      rd_chk(ADDR_STATUS, 32'h0000_0004);
      host.reg_write(ADDR_CTRL, 32'h0);
      host.reg_write(ADDR_CTRL, 32'ha000_0c00);
      repeat (20) @(posedge clk_in);
      #1;
      chk_out({n_int, n_frac}, CENTER, "no timer step");
      tx_settle(1'b1);
      chk_out({n_int, n_frac}, CENTER + N_W'(1), "pin step");
      tx_settle(1'b0);
      host.reg_write(ADDR_CTRL, host.safe_ctrl(32'h1000_0000));
      for (int i = 1; i <= 8; i++) begin
         pulse_predict();
         chk_out(N_W'(slip_cells), N_W'((1 << (i > 7 ? 7 : i)) - 1), "cells added");
      end
      chk_out(N_W'(slip_source), N_W'(1), "sourcing");
      prev_c = slip_cells;
      @(posedge clk_in);
      slip_overshoot <= 1'b1;
      for (int t = 0; t < 20; t++) begin
         @(posedge clk_in);
         if (t == 3) begin
            slip_overshoot <= 1'b0;
         end
         #1;
         if (slip_cells !== prev_c) begin
            chk_out(N_W'(slip_cells), N_W'(prev_c >> 1), "cell removed");
            prev_c = slip_cells;
         end
      end
      chk_out(N_W'(slip_cells), N_W'(0), "cells cleared");
      @(posedge clk_in);
      tune_up <= 1'b0;
      pulse_predict();
      chk_out(N_W'({slip_source, slip_cells}), N_W'(8'h01), "one sinking cell");
      host.reg_write(ADDR_CTRL, 32'h0);
      pulse_predict();
      chk_out(N_W'(slip_cells), N_W'(0), "slip logic off");
      finish_test();
   end

   initial begin
      #200_000;
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      finish_test();
   end
endmodule : fractional_ramp_modulator_tb
`default_nettype wire

// ===== verif/host_ctrl_model.sv
// Host model: drives the register port and the modulation pin
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
   // Clock
   input wire logic clk_in,
   // Register port
   output logic [ramp_mod_pkg::ADDR_W-1:0] reg_addr_out,
   output logic [ramp_mod_pkg::DATA_W-1:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [ramp_mod_pkg::DATA_W-1:0] reg_rdata_in,
   // Modulation pin
   output logic tx_data_out
);
   import ramp_mod_pkg::*;

   initial begin
      reg_addr_out = 6'h3f;
      reg_wdata_out = 32'h0;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      tx_data_out = 1'b0;
   end

   // --------------------------------
   // Register bus cycles
   // --------------------------------
   // Idle address and data are inverted so a stale value never looks valid
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask : reg_write

   task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      #1;
      d = reg_rdata_in;
   endtask : reg_read

   // --------------------------------
   // Settings and pin
   // --------------------------------
   // slip only at positive polarity
   function automatic logic [DATA_W-1:0] safe_ctrl(input logic [DATA_W-1:0] c);
      return c[CTRL_SLIP_BIT] ? (c | (32'h1 << CTRL_POL_BIT)) : c;
   endfunction : safe_ctrl

   function automatic logic [DATA_W-1:0] dev_word(input logic [15:0] w, input logic [3:0] s);
      return {12'h000, s, w};
   endfunction : dev_word

   // Three cycles per level, above the two-cycle minimum of the synchroniser
   task automatic tx_set(input logic v);
      @(posedge clk_in);
      tx_data_out <= v;
      repeat (3) @(posedge clk_in);
   endtask : tx_set
endmodule : host_ctrl_model
`default_nettype wire
